/* slave_sleep_ctl.sv */
// Purpose: sleep-mode wrapper with AXI4-Lite control and a component bus port
// Assumes: single clock, synchronous active-low reset
// Notes: component port uses read/write strobes with wait-request
`timescale 1ns/1ps
`include "sleep_ctl_cfg.svh"

// Notes on behaviour
// RULE1: one enable location, write zero/one
// RULE2: enable drives clock enable or reset
// RULE3: volatile mode holds component in reset
// RULE4: non-volatile mode keeps component state
// RULE5: bus stays alive while component sleeps
// RULE6: optional wake on first access
// RULE7: access reloads idle counter
// RULE8: idle cycle decrements counter
// RULE9: zero count sleeps until next access
// RULE10: wait-request held while waking
// RULE11: wait-request in first strobe cycle
// RULE12: interconnect marks first transfer cycle
// RULE13: OR late wait-request with begin-transfer
// RULE14: wait-request high before selection
// RULE15: strobes act as clock enables
// RULE16: clock enable masks combinational inputs
// RULE17: reset starts awake, counter loaded
module slave_sleep_ctl #(
  parameter int WAKE_CYC = `WAKE_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // axi4-lite register port
  input wire logic s_awvalid_in,
  output logic s_awready_out,
  input wire logic [7:0] s_awaddr_in,
  input wire logic s_wvalid_in,
  output logic s_wready_out,
  input wire logic [31:0] s_wdata_in,
  input wire logic [3:0] s_wstrb_in,
  output logic s_bvalid_out,
  input wire logic s_bready_in,
  output logic [1:0] s_bresp_out,
  input wire logic s_arvalid_in,
  output logic s_arready_out,
  input wire logic [7:0] s_araddr_in,
  output logic s_rvalid_out,
  input wire logic s_rready_in,
  output sleep_ctl_pkg::rd_rsp_s s_rrsp_out,
  // component bus port
  input wire logic comp_read_in,
  input wire logic comp_write_in,
  input wire logic comp_begin_in,
  output logic comp_wait_out,
  // controls toward the sleeping component
  output logic comp_clk_en_out,
  output logic comp_rst_n_out,
  output logic comp_rd_en_out,
  output logic comp_wr_en_out,
  output logic asleep_out
);
  import sleep_ctl_pkg::*;

  // the waking counter is eight bits wide
  if (WAKE_CYC < 1 || WAKE_CYC > 255) begin : g_bad_wake
    $error("WAKE_CYC out of range");
  end

  // ****************************************
  // register bus
  // ****************************************
  logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  wr_req_s wr_ff;
  rd_rsp_s rrsp_ff;
  logic enable_ff;
  logic [2:0] config_ff;
  logic [31:0] timeout_ff;
  logic [31:0] count_ff;
  sleep_state_e state_ff;
  logic [7:0] wake_cnt_ff;
  logic late_wait_ff;

  wire aw_take = s_awvalid_in && !aw_held_ff && !bvalid_ff;
  wire w_take = s_wvalid_in && !w_held_ff && !bvalid_ff;
  wire aw_have = aw_held_ff || aw_take;
  wire w_have = w_held_ff || w_take;
  wire wr_fire = aw_have && w_have && !bvalid_ff;
  wire [7:0] wr_addr = aw_held_ff ? wr_ff.addr : s_awaddr_in;
  wire [31:0] wr_data = w_held_ff ? wr_ff.data : s_wdata_in;
  wire [3:0] wr_strb = w_held_ff ? wr_ff.strb : s_wstrb_in;
  wire ar_take = s_arvalid_in && !rvalid_ff;

  function automatic logic known_ofs(input logic [7:0] a);
    known_ofs = (a == `REG_ENABLE_OFS) || (a == `REG_CONFIG_OFS) ||
      (a == `REG_TIMEOUT_OFS) || (a == `REG_STATUS_OFS) || (a == `REG_COUNT_OFS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  wire wr_en_reg = wr_fire && (wr_addr == `REG_ENABLE_OFS) && wr_strb[0]; // see RULE1
  wire wr_cfg_reg = wr_fire && (wr_addr == `REG_CONFIG_OFS) && wr_strb[0];
  wire wr_to_reg = wr_fire && (wr_addr == `REG_TIMEOUT_OFS);

  assign s_awready_out = !aw_held_ff && !bvalid_ff;
  assign s_wready_out = !w_held_ff && !bvalid_ff;
  assign s_bvalid_out = bvalid_ff;
  assign s_arready_out = !rvalid_ff;
  assign s_rvalid_out = rvalid_ff;
  assign s_rrsp_out = rrsp_ff;

  wire [31:0] status_word = {29'h0000_0000, state_ff == ST_WAKING,
                             state_ff == ST_ASLEEP, enable_ff};
  wire [31:0] rd_word =
    (s_araddr_in == `REG_ENABLE_OFS) ? {31'h0000_0000, enable_ff} :
    (s_araddr_in == `REG_CONFIG_OFS) ? {29'h0000_0000, config_ff} :
    (s_araddr_in == `REG_TIMEOUT_OFS) ? timeout_ff :
    (s_araddr_in == `REG_STATUS_OFS) ? status_word :
    (s_araddr_in == `REG_COUNT_OFS) ? count_ff : 32'h0000_0000;

  // the bus slave itself is never gated by sleep
  always_ff @(posedge core_clk_in) begin // see RULE5
    if (!nrst_in) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      wr_ff <= '0;
      rrsp_ff <= '0;
      s_bresp_out <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        wr_ff.addr <= s_awaddr_in;
      end
      if (w_take) begin
        wr_ff.data <= s_wdata_in;
        wr_ff.strb <= s_wstrb_in;
      end
      aw_held_ff <= wr_fire ? 1'b0 : aw_have;
      w_held_ff <= wr_fire ? 1'b0 : w_have;
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        s_bresp_out <= known_ofs(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_bready_in) begin
        bvalid_ff <= 1'b0;
      end
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rrsp_ff.data <= rd_word;
        rrsp_ff.resp <= known_ofs(s_araddr_in) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_rready_in) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // component strobes, pin synchronisers
  // ****************************************
  logic [2:0] rd_sync_ff, wr_sync_ff;
  logic rd_q_ff, wr_q_ff;
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rd_sync_ff <= 3'h0;
      wr_sync_ff <= 3'h0;
      rd_q_ff <= 1'b0;
      wr_q_ff <= 1'b0;
    end else begin
      rd_sync_ff <= {rd_sync_ff[1:0], comp_read_in};
      wr_sync_ff <= {wr_sync_ff[1:0], comp_write_in};
      if (rd_sync_ff[1] == rd_sync_ff[2]) begin
        rd_q_ff <= rd_sync_ff[2];
      end
      if (wr_sync_ff[1] == wr_sync_ff[2]) begin
        wr_q_ff <= wr_sync_ff[2];
      end
    end
  end

  wire access = rd_q_ff || wr_q_ff;
  wire hw_mode = config_ff[`CFG_HWMODE_BIT];
  wire auto_wake = config_ff[`CFG_AUTOWAKE_BIT];
  wire retain = config_ff[`CFG_RETAIN_BIT];
  wire awake = (state_ff == ST_AWAKE);

  // ****************************************
  // sleep state machine
  // ****************************************
  wire hw_expire = hw_mode && !access && (count_ff == 32'h0000_0001 || count_ff == '0);
  wire wake_req = (hw_mode && access) || (auto_wake && access) ||
                  (wr_en_reg && wr_data[0]);
  wire sleep_req = (wr_en_reg && !wr_data[0]) || hw_expire;
  wire [7:0] wake_last = 8'(WAKE_CYC - 1);

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      state_ff <= ST_AWAKE; // see RULE17
      enable_ff <= 1'b1;
      wake_cnt_ff <= 8'h00;
    end else begin
      unique case (state_ff)
        ST_AWAKE: begin
          if (sleep_req) begin // see RULE9
            state_ff <= ST_ASLEEP;
            enable_ff <= 1'b0;
          end
        end
        ST_ASLEEP: begin
          if (wake_req) begin // see RULE6
            state_ff <= ST_WAKING;
            enable_ff <= 1'b1;
            wake_cnt_ff <= 8'h00;
          end
        end
        ST_WAKING: begin
          if (wake_cnt_ff == wake_last) begin
            state_ff <= ST_AWAKE;
          end else begin
            wake_cnt_ff <= wake_cnt_ff + 8'h01;
          end
        end
      endcase
    end
  end

  // config, timeout and idle counter
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      config_ff <= `CONFIG_RST;
      timeout_ff <= `TIMEOUT_RST;
      count_ff <= `TIMEOUT_RST; // see RULE17
    end else begin
      if (wr_cfg_reg) begin // see RULE1
        config_ff <= wr_data[2:0];
      end
      if (wr_to_reg) begin
        timeout_ff <= merge(timeout_ff, wr_data, wr_strb);
      end
      if (access) begin
        count_ff <= timeout_ff; // see RULE7
      end else if (hw_mode && awake && count_ff != '0) begin
        count_ff <= count_ff - 32'h0000_0001; // see RULE8
      end
    end
  end

  // ****************************************
  // component controls and wait-request
  // ****************************************
  // retained mode gates the clock, volatile mode holds reset
  assign comp_clk_en_out = retain ? awake : 1'b1; // see RULE4
  assign comp_rst_n_out = retain ? 1'b1 : enable_ff; // see RULE2
  assign asleep_out = !enable_ff; // see RULE3
  // strobes gate the inputs, masked while not awake
  assign comp_rd_en_out = rd_q_ff && awake; // see RULE15
  assign comp_wr_en_out = wr_q_ff && awake; // see RULE16

  // registered wait lags a cycle; begin-transfer covers that cycle
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      late_wait_ff <= 1'b1;
    end else begin
      // only the synchronised strobe lowers it; the raw pin may be metastable
      late_wait_ff <= !awake || !access; // see RULE14
    end
  end
  // held high while idle so the first strobe cycle is stalled
  assign comp_wait_out = late_wait_ff || comp_begin_in || !awake; // see RULE10 RULE11 RULE13

  // ****************************************
  // checks
  // ****************************************
  a_begin_stalls: assert property ( // see RULE11
    @(posedge core_clk_in) disable iff (!nrst_in)
    comp_begin_in |-> comp_wait_out)
    else $error("begin-transfer cycle not stalled");
  a_waking_waits: assert property ( // see RULE10
    @(posedge core_clk_in) disable iff (!nrst_in)
    state_ff == ST_WAKING |-> comp_wait_out)
    else $error("wait dropped while waking");
  a_idle_waits: assert property ( // see RULE14
    @(posedge core_clk_in) disable iff (!nrst_in)
    (awake && !comp_read_in && !comp_write_in && !access) |=> comp_wait_out)
    else $error("wait low while unselected");
  a_reload_count: assert property ( // see RULE7
    @(posedge core_clk_in) disable iff (!nrst_in)
    (access && !wr_to_reg) |=> count_ff == $past(timeout_ff))
    else $error("access did not reload counter");
  a_count_down: assert property ( // see RULE8
    @(posedge core_clk_in) disable iff (!nrst_in)
    (hw_mode && awake && !access && count_ff > 32'h0000_0001) |=>
      count_ff == $past(count_ff) - 32'h0000_0001)
    else $error("idle counter did not decrement");
  a_expire_sleep: assert property ( // see RULE9
    @(posedge core_clk_in) disable iff (!nrst_in)
    (awake && hw_expire && !wake_req) |=> state_ff == ST_ASLEEP && asleep_out)
    else $error("expired counter did not sleep");
  a_volatile_rst: assert property ( // see RULE3
    @(posedge core_clk_in) disable iff (!nrst_in)
    (!retain && state_ff == ST_ASLEEP) |-> !comp_rst_n_out)
    else $error("volatile sleep not in reset");
  a_retain_gate: assert property ( // see RULE4
    @(posedge core_clk_in) disable iff (!nrst_in)
    (retain && state_ff == ST_ASLEEP) |-> !comp_clk_en_out && comp_rst_n_out)
    else $error("retained sleep reset the component");
  a_enable_write: assert property ( // see RULE1
    @(posedge core_clk_in) disable iff (!nrst_in)
    (wr_en_reg && !wr_data[0] && awake) |=> !enable_ff)
    else $error("enable write ignored");
  a_bus_alive: assert property ( // see RULE5
    @(posedge core_clk_in) disable iff (!nrst_in)
    (s_arvalid_in && !rvalid_ff) |=> s_rvalid_out)
    else $error("register read not answered");
  a_wake_bound: assert property ( // see RULE10
    @(posedge core_clk_in) disable iff (!nrst_in)
    $rose(state_ff == ST_WAKING) |-> ##[1:256] awake)
    else $error("wake took too long");
  a_mask_asleep: assert property ( // see RULE16
    @(posedge core_clk_in) disable iff (!nrst_in)
    !awake |-> !comp_rd_en_out && !comp_wr_en_out)
    else $error("strobe passed while not awake");
  a_strobe_pass: assert property ( // see RULE15
    @(posedge core_clk_in) disable iff (!nrst_in)
    (awake && (rd_q_ff || wr_q_ff)) |-> (comp_rd_en_out || comp_wr_en_out))
    else $error("strobe not passed while awake");
  a_volatile_clk: assert property ( // see RULE2
    @(posedge core_clk_in) disable iff (!nrst_in)
    !retain |-> comp_clk_en_out)
    else $error("volatile mode gated the clock");
  a_asleep_flag: assert property ( // see RULE9
    @(posedge core_clk_in) disable iff (!nrst_in)
    asleep_out == (state_ff == ST_ASLEEP))
    else $error("asleep flag disagrees with state");
  a_sleep_holds: assert property ( // see RULE9
    @(posedge core_clk_in) disable iff (!nrst_in)
    (state_ff == ST_ASLEEP && !wake_req) |=> state_ff == ST_ASLEEP)
    else $error("left sleep without a wake request");
  a_access_wakes: assert property ( // see RULE6
    @(posedge core_clk_in) disable iff (!nrst_in)
    (state_ff == ST_ASLEEP && auto_wake && access) |=> state_ff == ST_WAKING)
    else $error("access did not wake the component");
  a_write_answer: assert property ( // see RULE5
    @(posedge core_clk_in) disable iff (!nrst_in)
    wr_fire |=> s_bvalid_out)
    else $error("register write not answered");
endmodule

/* sleep_ctl_cfg.svh */
// Purpose: constants for the sleep-mode wrapper
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: offsets are byte addresses of aligned words
`ifndef SLEEP_CTL_CFG_SVH
`define SLEEP_CTL_CFG_SVH
`define REG_ENABLE_OFS 8'h00
`define REG_CONFIG_OFS 8'h04
`define REG_TIMEOUT_OFS 8'h08
`define REG_STATUS_OFS 8'h0C
`define REG_COUNT_OFS 8'h10
`define CFG_HWMODE_BIT 0
`define CFG_AUTOWAKE_BIT 1
`define CFG_RETAIN_BIT 2
`define CONFIG_RST 3'h0
`define TIMEOUT_RST 32'h0000_0400
`define WAKE_CYCLES 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* sleep_ctl_pkg.sv */
// Purpose: types for the sleep-mode wrapper
// Assumes: nothing beyond the cfg header
// Notes: bus channels carried as packed structs
package sleep_ctl_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wr_req_s;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } rd_rsp_s;
  typedef enum logic [1:0] {
    ST_AWAKE,
    ST_ASLEEP,
    ST_WAKING
  } sleep_state_e;
endpackage

/* comp_master_model.sv */
// Purpose: component-bus master seen through the interconnect
// Assumes: one transfer at a time, single clock
// Notes: strobe held until wait-request is sampled low
`timescale 1ns/1ps
module comp_master_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic wr_in,
  input wire logic wait_in,
  output logic read_out,
  output logic write_out,
  output logic begin_out,
  output logic done_out,
  output logic [7:0] wait_cnt_out
);
  logic busy_ff;
  initial begin
    busy_ff = 1'b0;
    read_out = 1'b0;
    write_out = 1'b0;
    begin_out = 1'b0;
    done_out = 1'b0;
    wait_cnt_out = 8'h00;
  end
  // wait is read at the rising edge, before this edge's updates land
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    begin_out <= 1'b0;
    if (!busy_ff && go_in) begin
      busy_ff <= 1'b1;
      read_out <= !wr_in;
      write_out <= wr_in;
      begin_out <= 1'b1;
      wait_cnt_out <= 8'h00;
    end else if (busy_ff && !wait_in) begin
      busy_ff <= 1'b0;
      read_out <= 1'b0;
      write_out <= 1'b0;
      done_out <= 1'b1;
    end else if (busy_ff) begin
      wait_cnt_out <= wait_cnt_out + 8'h01;
    end
  end
endmodule

/* slave_sleep_mode_controller_test.sv */
// Purpose: self-checking bench for the sleep-mode wrapper
// Assumes: partner model drives the component bus
// Notes: register reads are scored through a queue
`timescale 1ns/1ps
`include "sleep_ctl_cfg.svh"
module slave_sleep_mode_controller_test;
  import sleep_ctl_pkg::*;
  localparam int WK = 4;
  logic clk = 1'b0;
  logic nrst, awv, wv, bry, arv, rry, go, gowr;
  logic awr, wrd, bv, arr, rv, wt, cke, rstn, rde, wre, slp, crd, cwr, cbeg, cdone;
  logic [7:0] awa, ara, wcnt;
  logic [31:0] wd;
  logic [1:0] br;
  rd_rsp_s rr;
  rd_rsp_s exp_q[$];
  int mismatches = 0;
  int samples_checked = 0;
  int t;
  logic [31:0] seed = 32'h0000EC70;
  always #2.5 clk = ~clk;
  slave_sleep_ctl #(.WAKE_CYC(WK)) i_dut (.core_clk_in(clk), .nrst_in(nrst),
    .s_awvalid_in(awv), .s_awready_out(awr), .s_awaddr_in(awa), .s_wvalid_in(wv),
    .s_wready_out(wrd), .s_wdata_in(wd), .s_wstrb_in(4'hF), .s_bvalid_out(bv),
    .s_bready_in(bry), .s_bresp_out(br), .s_arvalid_in(arv), .s_arready_out(arr),
    .s_araddr_in(ara), .s_rvalid_out(rv), .s_rready_in(rry), .s_rrsp_out(rr),
    .comp_read_in(crd), .comp_write_in(cwr), .comp_begin_in(cbeg), .comp_wait_out(wt),
    .comp_clk_en_out(cke), .comp_rst_n_out(rstn), .comp_rd_en_out(rde),
    .comp_wr_en_out(wre), .asleep_out(slp));
  comp_master_model i_master (.clk_in(clk), .go_in(go), .wr_in(gowr), .wait_in(wt),
    .read_out(crd), .write_out(cwr), .begin_out(cbeg), .done_out(cdone),
    .wait_cnt_out(wcnt));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ha, hw, hb;
    hb = 0;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bry <= 1'b1;
    while (!hb) begin
      @(negedge clk);
      ha = awv && awr;
      hw = wv && wrd;
      hb = bv && bry;
      if (hb) chk("bresp", br, `RESP_OKAY);
      @(posedge clk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      if (hb) bry <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ha, hr;
    hr = 0;
    exp_q.push_back({d, r});
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    while (!hr) begin
      @(negedge clk);
      ha = arv && arr;
      hr = rv && rry;
      @(posedge clk);
      if (ha) arv <= 1'b0;
      if (hr) rry <= 1'b0;
    end
  endtask
  task automatic access(input logic w);
    int n;
    @(posedge clk);
    go <= 1'b1;
    gowr <= w;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 300 && !cdone; n++) @(negedge clk);
    chk("done", cdone, 1'b1);
  endtask
  always @(negedge clk) begin
    if (rv && rry) begin
      chk("rdata", rr.data, exp_q[0].data);
      chk("rresp", rr.resp, exp_q[0].resp);
      void'(exp_q.pop_front());
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {nrst, awv, wv, bry, arv, rry, go, gowr} <= 8'h00;
    {awa, ara, wd} <= 48'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(`REG_ENABLE_OFS, 32'h1, `RESP_OKAY);
    rd(`REG_CONFIG_OFS, 32'h0, `RESP_OKAY);
    rd(`REG_TIMEOUT_OFS, `TIMEOUT_RST, `RESP_OKAY);
    rd(8'h14, 32'h0, `RESP_SLVERR);
    $display("test reset_values done");
    wr(`REG_ENABLE_OFS, 32'h0);
    chk("asleep", slp, 1'b1);
    chk("rst_n", rstn, 1'b0);
    chk("rd_en", rde, 1'b0);
    rd(`REG_STATUS_OFS, 32'h2, `RESP_OKAY);
    wr(`REG_ENABLE_OFS, 32'h1);
    repeat (WK + 2) @(posedge clk);
    chk("asleep", slp, 1'b0);
    chk("rst_n", rstn, 1'b1);
    $display("test volatile done");
    wr(`REG_CONFIG_OFS, 32'h4);
    wr(`REG_ENABLE_OFS, 32'h0);
    chk("clk_en", cke, 1'b0);
    chk("rst_n", rstn, 1'b1);
    wr(`REG_ENABLE_OFS, 32'h1);
    repeat (WK + 2) @(posedge clk);
    chk("clk_en", cke, 1'b1);
    $display("test retain done");
    wr(`REG_CONFIG_OFS, 32'h2);
    wr(`REG_ENABLE_OFS, 32'h0);
    access(1'b0);
    chk("rd_en", rde, 1'b1);
    chk("wake_wait", wcnt >= WK, 1'b1);
    chk("asleep", slp, 1'b0);
    $display("test auto_wake done");
    t = 8 + int'(xs() % 16);
    wr(`REG_TIMEOUT_OFS, 32'(t));
    wr(`REG_CONFIG_OFS, 32'h1);
    access(1'b1);
    chk("wr_en", wre, 1'b1);
    chk("first_wait", wcnt >= 1, 1'b1);
    repeat (t - 2) @(posedge clk);
    chk("asleep", slp, 1'b0);
    repeat (10) @(posedge clk);
    chk("asleep", slp, 1'b1);
    access(1'b0);
    chk("wake_wait", wcnt >= WK, 1'b1);
    chk("asleep", slp, 1'b0);
    $display("test hw_timeout done");
    tally_and_finish();
  end
  // tests need under 1000 cycles; 20000 leaves ample margin
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end
endmodule
